// ==== tcr_readout.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcr_params.svh"

module tcr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk_i, // block clock
  input  wire logic             rst_i,      // sync reset
  input  wire logic             in_valid_i, // write request
  output logic                  in_ready_o, // not full
  input  wire logic [WIDTH-1:0] in_data_i,  // write data
  output logic                  out_valid_o,// not empty
  input  wire logic             out_ready_i,// drain request
  output logic      [WIDTH-1:0] out_data_o  // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              do_wr = in_valid_i && in_ready_o;
  wire              do_rd = out_valid_o && out_ready_i;
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  // pointers and count; simultaneous read and write keep count
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
  // storage has no reset, only the head matters once valid
  always_ff @(posedge core_clk_i) begin
    if (do_wr) mem[wr_ptr] <= in_data_i;
  end
endmodule

module tcr_readout #(
  parameter int CONV_CYCLES = `TCR_CONV_CYCLES
) (
  input  wire logic       core_clk_i,        // block clock, 10 MHz
  input  wire logic       rst_i,             // sync reset, active high
  input  wire logic       chip_select_n_i,   // host chip select, low
  input  wire logic       serial_clk_i,      // host serial clock pin
  output logic            serial_data_out_o, // serial data level
  output logic            serial_data_oe_o,  // high while driving
  input  wire logic [9:0] ambient_code_i,    // cold-junction measure
  input  wire logic [9:0] diff_code_i,       // amplified difference
  input  wire logic       open_detect_i,     // open input, async
  output logic            converting_o       // conversion running
);
  tcr_pkg::tcr_state_e state;
  tcr_pkg::tcr_state_e next_state;
  logic [2:0]  cs_sync;   // [0] first stage, [1] second, [2] previous
  logic [2:0]  sck_sync;
  logic [1:0]  open_sync;
  logic [31:0] conv_cnt;
  logic [4:0]  bit_idx;
  logic [`TCR_WORD_BITS-1:0] shift_word;
  tcr_pkg::tcr_result_s result;
  tcr_pkg::tcr_result_s conv_value;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [10:0] fifo_out_data;
  // a pin can move at any instant; two stages settle it before use,
  // and the third stage is only history for the edge detectors
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_sync <= 3'h7;                    // idle level, no false edge
    end else begin
      cs_sync <= {cs_sync[1], cs_sync[0], chip_select_n_i};
    end
  end
  // serial clock idles low between frames
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sck_sync <= 3'h0;
    end else begin
      sck_sync <= {sck_sync[1], sck_sync[0], serial_clk_i};
    end
  end
  // open detector is a slow level, two stages suffice
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      open_sync <= 2'h0;
    end else begin
      open_sync <= {open_sync[0], open_detect_i};
    end
  end
  // edges come from the second and third stages only
  wire cs_low   = ~cs_sync[1];
  wire cs_fall  = cs_sync[2] & ~cs_sync[1];
  wire cs_rise  = ~cs_sync[2] & cs_sync[1];
  wire sck_fall = sck_sync[2] & ~sck_sync[1];
  // saturating sum, code scale is 0.125 degree per step
  wire [10:0] raw_sum = {1'b0, ambient_code_i} + {1'b0, diff_code_i};
  wire [9:0]  sum_code = raw_sum[10] ? 10'h3ff : raw_sum[9:0];
  wire        conv_done = (state == tcr_pkg::TCR_CONVERT) &&
                          (conv_cnt == 32'(CONV_CYCLES - 1));
  assign conv_value.open_input_flag  = open_sync[1];
  assign conv_value.temperature_code = sum_code;
  // word assembly from the last finished result
  wire [`TCR_WORD_BITS-1:0] load_word = {
    1'b0,
    result.temperature_code,
    result.open_input_flag,
    `TCR_IDENT_VALUE,
    3'h0};
  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      tcr_pkg::TCR_IDLE: begin
        if (cs_fall) begin
          next_state = tcr_pkg::TCR_SHIFT;
        end else if (cs_rise) begin
          next_state = tcr_pkg::TCR_CONVERT;
        end
      end
      tcr_pkg::TCR_CONVERT: begin
        // a select fall wins over a conversion finishing that cycle
        if (cs_fall) begin
          next_state = tcr_pkg::TCR_SHIFT;
        end else if (conv_done) begin
          next_state = tcr_pkg::TCR_IDLE;
        end
      end
      tcr_pkg::TCR_SHIFT: begin
        if (cs_rise) begin
          next_state = tcr_pkg::TCR_CONVERT;
        end
      end
      default: begin
        next_state = tcr_pkg::TCR_IDLE;
      end
    endcase
  end
  // conversion timer; restarts only on a fresh chip select rise,
  // and any exit from converting clears it, so aborts leave no residue
  always_ff @(posedge core_clk_i) begin
    if (rst_i || state != tcr_pkg::TCR_CONVERT) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + 32'h1;
    end
  end
  // state register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= tcr_pkg::TCR_IDLE;
    end else begin
      state <= next_state;
    end
  end
  // finished results go through the fifo, newest drained into result
  // aborted conversions never write, so result stays intact
  tcr_fifo #(.WIDTH(11), .DEPTH(`TCR_FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (conv_done && !cs_fall),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (conv_value),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (!cs_low),
    .out_data_o  (fifo_out_data)
  );
  // result only moves while no read is in progress
  always_ff @(posedge core_clk_i) begin
    if (rst_i) result <= `TCR_RESULT_RESET;
    else if (fifo_out_valid && !cs_low) result <= fifo_out_data;
  end
  // a bit step needs select low and stops after the sixteenth fall
  wire shift_step = cs_low && sck_fall &&
                    (bit_idx != 5'(`TCR_WORD_BITS));
  wire [`TCR_WORD_BITS-1:0] shifted_word =
    {shift_word[`TCR_WORD_BITS-2:0], 1'b0};
  // shift register and bit pointer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      shift_word <= '0;
      bit_idx    <= 5'h0;
    end else if (cs_fall) begin
      shift_word <= load_word;
      bit_idx    <= 5'h0;
    end else if (shift_step) begin
      shift_word <= shifted_word;
      bit_idx    <= bit_idx + 5'h1;
    end
  end
  // output pin: driven for the first thirteen bit times only
  wire in_tail   = bit_idx >= 5'(`TCR_WORD_BITS - `TCR_TAIL_TOP - 1);
  // the loaded word is used directly at the select fall, one clock early
  wire head_bit  = cs_fall ? load_word[`TCR_LEAD_POS]
                           : shift_word[`TCR_LEAD_POS];
  wire next_data = (next_state == tcr_pkg::TCR_SHIFT) && head_bit;
  // a stale pointer from the last read must not hide the lead bit
  wire next_oe   = cs_low && !(in_tail && !cs_fall);
  wire next_conv = (next_state == tcr_pkg::TCR_CONVERT);
  // registered pins, no glitches toward the host
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      serial_data_out_o <= 1'b0;
      serial_data_oe_o  <= 1'b0;
      converting_o      <= 1'b0;
    end else begin
      serial_data_out_o <= next_data;
      serial_data_oe_o  <= next_oe;
      converting_o      <= next_conv;
    end
  end
  wire unused_ok = fifo_in_ready;
endmodule
`default_nettype wire

// ==== tcr_params.svh ====
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH
// word layout
`define TCR_WORD_BITS      16
`define TCR_LEAD_POS       15
`define TCR_TEMP_MSB       14
`define TCR_TEMP_LSB       5
`define TCR_OPEN_POS       4
`define TCR_IDENT_POS      3
`define TCR_TAIL_TOP       2
// identification bit value, arbitrary
`define TCR_IDENT_VALUE    1'b1
// conversion time in ms and its cycle count at 10 MHz
`define TCR_CONV_MS        180
`define TCR_CLK_KHZ        10000
`define TCR_CONV_CYCLES    (`TCR_CONV_MS * `TCR_CLK_KHZ)
// reset value and fifo depth
`define TCR_RESULT_RESET   11'h000
`define TCR_FIFO_DEPTH     16
`endif

// ==== tcr_pkg.sv ====
`default_nettype none
package tcr_pkg;
  // one stored conversion result
  typedef struct packed {
    logic       open_input_flag;
    logic [9:0] temperature_code;
  } tcr_result_s;
  typedef enum logic [1:0] {
    TCR_IDLE    = 2'b00,
    TCR_CONVERT = 2'b01,
    TCR_SHIFT   = 2'b11
  } tcr_state_e;
endpackage
`default_nettype wire

// ==== tcr_readout_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcr_readout_checker (
  input wire logic core_clk_i,        // block clock
  input wire logic rst_i,             // sync reset
  input wire logic chip_select_n_i,   // host select
  input wire logic serial_clk_i,      // host link clock
  input wire logic serial_data_out_o, // data level
  input wire logic serial_data_oe_o,  // data enable
  input wire logic converting_o       // conversion running
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // select seen low or high, lead bit driven
  sequence sel_fall_s; $fell(chip_select_n_i); endsequence
  sequence sel_rise_s; $rose(chip_select_n_i); endsequence
  sequence lead_out_s; serial_data_oe_o && !serial_data_out_o; endsequence
  idle_quiet_a: assert property (
    chip_select_n_i[*6] |-> !serial_data_oe_o)
    else $error("data enabled while deselected");
  first_bit_a: assert property (
    sel_fall_s |-> ##[1:6] lead_out_s)
    else $error("lead bit missing after select");
  lead_zero_a: assert property (
    $rose(serial_data_oe_o) |-> !serial_data_out_o)
    else $error("lead bit not zero");
  conv_abort_a: assert property (
    sel_fall_s |-> ##[1:6] !converting_o)
    else $error("conversion not aborted");
  conv_held_a: assert property (
    (!chip_select_n_i)[*6] |-> !converting_o)
    else $error("conversion while selected");
  conv_start_a: assert property (
    sel_rise_s |-> ##[1:8] converting_o)
    else $error("conversion not started");
  oe_release_a: assert property (
    sel_rise_s |-> ##[1:6] !serial_data_oe_o)
    else $error("data not released");
  // data may only move after a link clock fall
  bit_hold_a: assert property (
    (!chip_select_n_i && serial_clk_i)[*3] |-> $stable(serial_data_out_o))
    else $error("data moved");
endmodule
bind tcr_readout tcr_readout_checker u_chk (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .chip_select_n_i(chip_select_n_i),
  .serial_clk_i(serial_clk_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_oe_o(serial_data_oe_o), .converting_o(converting_o));
`default_nettype wire

// ==== tcr_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcr_host_model (
  input  wire logic core_clk_i,      // paces the link
  input  wire logic data_i,          // serial data line
  output var logic  chip_select_n_o, // select, active low
  output var logic  serial_clk_o     // link clock, still between frames
);
  initial begin
    chip_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
  end
  // four core cycles make half of the 800 ns link period
  task automatic half();
    repeat (4) @(negedge core_clk_i);
  endtask
  // short select pulse: aborts, then restarts on the rise
  task automatic restart();
    chip_select_n_o = 1'b0;
    half();
    half();
    chip_select_n_o = 1'b1;
  endtask
  // one whole read, bits taken on the clock fall
  task automatic read_word(output logic [15:0] w);
    chip_select_n_o = 1'b0;
    half();
    half();
    for (int i = 15; i >= 0; i--) begin
      serial_clk_o = 1'b1;
      half();
      serial_clk_o = 1'b0;
      w[i] = data_i;
      half();
    end
    chip_select_n_o = 1'b1;
    half(); // deselect gap, so the next select fall is a true edge
  endtask
endmodule
`default_nettype wire

// ==== tcr_readout_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tcr_params.svh"
module tcr_readout_tb_top;
  localparam int SIM_CONV = 50; // short conversion for simulation
  logic        clk, rst, cs_n, sck, sdo, oe, conv, opn, last_q;
  logic [9:0]  amb, dif;
  logic [15:0] word, en;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // released line shows the inverse of its last level, never a held value
  wire         line = oe ? sdo : ~last_q;
  tcr_readout #(.CONV_CYCLES(SIM_CONV)) u_dut (.core_clk_i(clk), .rst_i(rst),
    .chip_select_n_i(cs_n), .serial_clk_i(sck), .serial_data_out_o(sdo),
    .serial_data_oe_o(oe), .ambient_code_i(amb), .diff_code_i(dif),
    .open_detect_i(opn), .converting_o(conv));
  tcr_host_model u_host (.core_clk_i(clk), .data_i(line),
    .chip_select_n_o(cs_n), .serial_clk_o(sck));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // enable history at each link clock fall
  always @(negedge sck) en <= {en[14:0], oe};
  always @(posedge clk) begin
    if (oe) last_q <= sdo;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // new inputs, restart, wait w cycles, then read and judge the word
  task conv_read(input logic [9:0] a, input logic [9:0] d, input logic o,
                 input int w, input logic [9:0] code, input logic oc);
    logic [15:0] exp_word;
    amb = a;
    dif = d;
    opn = o;
    u_host.restart();
    repeat (w) @(negedge clk);
    chk({15'h0000, conv}, {15'h0000, w < SIM_CONV});
    u_host.read_word(word);
    exp_word = {1'b0, code, oc, `TCR_IDENT_VALUE, 3'h0};
    chk(word & 16'hfff8, exp_word);
    chk(en, 16'hfff8);
  endtask
  // zero degrees reads an all zero code
  task scen_zero();
    conv_read(10'h000, 10'h000, 1'b0, 80, 10'h000, 1'b0);
  endtask
  // ambient plus amplified difference
  task scen_sum();
    conv_read(10'h100, 10'h055, 1'b0, 80, 10'h155, 1'b0);
  endtask
  // overflow clamps to all ones, open input flagged
  task scen_top_open();
    conv_read(10'h3ff, 10'h001, 1'b1, 80, 10'h3ff, 1'b1);
  endtask
  // read during a conversion aborts it and returns the old word
  task scen_abort();
    conv_read(10'h002, 10'h002, 1'b0, 10, 10'h3ff, 1'b1);
  endtask
  // deselect starts a fresh conversion
  task scen_fresh();
    conv_read(10'h002, 10'h002, 1'b0, 80, 10'h004, 1'b0);
  endtask
  task results();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    amb = 10'h000;
    dif = 10'h000;
    opn = 1'b0;
    last_q = 1'b0;
    en = 16'h0000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    scen_zero();
    scen_sum();
    scen_top_open();
    scen_abort();
    scen_fresh();
    results();
  end
endmodule
`default_nettype wire
